// ===== rtl/css_config_select.sv
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`default_nettype none
module css_config_select
  import css_pkg::*;
#(
  parameter int NUM_SETS = CSS_NUM_SETS
) (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write channels.
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Received frame from the CAN controller.
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic [28:0] rx_id,
  input  wire logic        rx_ide,
  input  wire logic [3:0]  rx_dlc,
  input  wire logic [63:0] rx_data,
  // Reply frame to the CAN controller.
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [28:0]      tx_id,
  output logic             tx_ide,
  output logic [3:0]       tx_dlc,
  output logic [63:0]      tx_data,
  // Machine state pins.
  input  wire logic        standstill_pin,
  input  wire logic        lever_neutral_pin,
  input  wire logic        park_brake_fitted_pin,
  input  wire logic        park_brake_on_pin,
  input  wire logic        restart_pin,
  // Interrupt.
  output logic             irq
);
  // ****************************************************************
  // Pin synchronisation and machine readiness.
  // ****************************************************************
  logic [CSS_NUM_PINS-1:0] pins_q;      // Synchronised pin levels.
  logic                    restart_d;   // Previous restart level for the edge.
  logic                    restart_edge; // One cycle at a restart.
  logic                    machine_ok;  // All machine preconditions for a write met.

  css_sync #(.W(CSS_NUM_PINS)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d_in    ({restart_pin, park_brake_on_pin, park_brake_fitted_pin,
               lever_neutral_pin, standstill_pin}),
    .q_out   (pins_q)
  );

  // Standstill and neutral always; the brake only where one is fitted.
  assign machine_ok = pins_q[0] && pins_q[1] && (!pins_q[2] || pins_q[3]);

  // Remember the restart level so that a held pin counts once.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      restart_d <= 1'b0;
    end else begin
      restart_d <= pins_q[4];
    end
  end
  assign restart_edge = pins_q[4] && !restart_d;

  // ****************************************************************
  // Register state.
  // ****************************************************************
  logic                  enable_reg;     // Frame handling enabled.
  logic                  clr_act_reg;    // One-cycle request to drop the set.
  logic [CSS_NUM_EV-1:0] status_reg;     // Sticky events.
  logic [CSS_NUM_EV-1:0] mask_reg;       // Interrupt enables.
  logic [7:0]            active_reg;     // Active set index or FFh.
  logic [7:0]            pending_reg;    // Set to activate at restart.
  logic                  active_valid;   // Active index names a real set.
  logic [15:0]           par_reg [CSS_NUM_PAR]; // Parameters of the set.
  css_state_t            state_reg;      // Frame handler state.

  assign active_valid = active_reg < 8'(NUM_SETS);

  // ****************************************************************
  // Frame decode.
  // ****************************************************************
  logic                  take;        // A frame is accepted this cycle.
  logic                  id_ok;       // Identifier and length match.
  logic [7:0]            b1;          // Request code byte.
  logic [7:0]            b2;          // Operation or parameter index.
  logic [7:0]            b3;          // Set index, field or value high.
  logic [7:0]            b4;          // Value low byte.
  logic [CSS_PI_W-1:0]   pidx;        // Parameter index.
  logic                  pidx_ok;     // Index names a parameter.
  logic [15:0]           new_val;     // Value of a parameter write.
  logic                  reply_go;    // A reply is owed.
  logic [63:0]           reply_next;  // Reply payload.
  logic                  pend_we;     // Accept a new pending set.
  logic                  par_we;      // Store a parameter value.
  logic [CSS_NUM_EV-1:0] ev;          // Events of this cycle.

  assign take    = rx_valid && rx_ready;
  // Only the low four bytes carry meaning; the rest are not looked at.
  assign b1      = rx_data[7:0];
  assign b2      = rx_data[15:8];
  assign b3      = rx_data[23:16];
  assign b4      = rx_data[31:24];
  assign pidx    = b2[CSS_PI_W-1:0];
  assign pidx_ok = b2 < 8'(CSS_NUM_PAR);
  assign new_val = {b3, b4};
  // Requests come from any sender address in the low byte.
  assign id_ok   = rx_ide && (rx_dlc == CSS_DLC) && (rx_id[28:8] == CSS_REQ_ID_HI);

  // Build the reply and side effects of the accepted frame.
  always_comb begin
    reply_go   = 1'b0;
    pend_we    = 1'b0;
    par_we     = 1'b0;
    ev         = '0;
    reply_next = {8{CSS_FILL}};
    if (take && id_ok && enable_reg) begin
      case (b1)
        CSS_CODE_SEL: begin
          reply_next[7:0]   = b1;
          reply_next[31:24] = active_reg;
          if (b2 == CSS_OP_READ) begin
            // Byte 3 of a read request has no influence.
            reply_go          = 1'b1;
            reply_next[15:8]  = b2;
            reply_next[23:16] = active_reg;
            ev[CSS_EV_SELRD]  = 1'b1;
          end else if (b2 == CSS_OP_WRITE) begin
            reply_go = 1'b1;
            if (b3 < 8'(NUM_SETS)) begin
              pend_we           = 1'b1;
              reply_next[15:8]  = b2;
              reply_next[23:16] = b3;
              ev[CSS_EV_SELOK]  = 1'b1;
            end else begin
              // Refused: both selections stay as they were.
              reply_next[15:8]  = CSS_OP_BAD;
              reply_next[23:16] = active_reg;
              ev[CSS_EV_SELBAD] = 1'b1;
            end
          end else begin
            // Unknown operations get no reply.
            reply_go = 1'b0;
          end
        end
        CSS_CODE_PRD: begin
          reply_go          = 1'b1;
          reply_next[15:0]  = {b2, b1};
          reply_next[31:16] = 16'hFFFF;
          if (!active_valid) begin
            reply_next[39:32] = CSS_ST_NOSET;
            ev[CSS_EV_PARBAD] = 1'b1;
          end else if (!pidx_ok) begin
            reply_next[39:32] = CSS_ST_INDEX;
            ev[CSS_EV_PARBAD] = 1'b1;
          end else begin
            // Reads need no machine condition at all.
            reply_next[39:32] = CSS_ST_OK;
            ev[CSS_EV_PAROK]  = 1'b1;
            if (b3 == CSS_FLD_MIN) begin
              reply_next[31:16] = {CSS_PAR_MIN[pidx][7:0], CSS_PAR_MIN[pidx][15:8]};
            end else if (b3 == CSS_FLD_MAX) begin
              reply_next[31:16] = {CSS_PAR_MAX[pidx][7:0], CSS_PAR_MAX[pidx][15:8]};
            end else begin
              reply_next[31:16] = {par_reg[pidx][7:0], par_reg[pidx][15:8]};
            end
          end
        end
        CSS_CODE_PWR: begin
          reply_go          = 1'b1;
          reply_next[31:0]  = {b4, b3, b2, b1};
          ev[CSS_EV_PARBAD] = 1'b1;
          // Checks in order: set, machine, index, range.
          if (!active_valid) begin
            reply_next[39:32] = CSS_ST_NOSET;
          end else if (!machine_ok) begin
            reply_next[39:32] = CSS_ST_MACH;
          end else if (!pidx_ok) begin
            reply_next[39:32] = CSS_ST_INDEX;
          end else if (new_val < CSS_PAR_MIN[pidx] || new_val > CSS_PAR_MAX[pidx]) begin
            reply_next[39:32] = CSS_ST_RANGE;
          end else begin
            reply_next[39:32] = CSS_ST_OK;
            par_we            = 1'b1;
            ev[CSS_EV_PARBAD] = 1'b0;
            ev[CSS_EV_PAROK]  = 1'b1;
          end
        end
        default: begin
          reply_go = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Frame handshake and reply register.
  // ****************************************************************
  // One frame at a time: a new request waits until the reply has left,
  // so no reply is ever overwritten.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= CSS_IDLE;
      rx_ready  <= 1'b0;
      tx_valid  <= 1'b0;
      tx_id     <= '0;
      tx_ide    <= 1'b1;
      tx_dlc    <= CSS_DLC;
      tx_data   <= '0;
    end else begin
      case (state_reg)
        CSS_IDLE: begin
          rx_ready <= 1'b1;
          if (take && reply_go) begin
            state_reg <= CSS_REPLY;
            rx_ready  <= 1'b0;
            tx_valid  <= 1'b1;
            tx_id     <= {CSS_RPL_ID_HI, CSS_OWN_ADDR};
            tx_data   <= reply_next;
          end
        end
        CSS_REPLY: begin
          if (tx_ready) begin
            state_reg <= CSS_IDLE;
            tx_valid  <= 1'b0;
            rx_ready  <= 1'b1;
          end
        end
        default: begin
          state_reg <= CSS_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Set selection: pending and active index.
  // ****************************************************************
  // A running machine never switches sets; the restart pin marks the
  // end of a controlled power-down and only then is the pending set taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending_reg <= CSS_ACTIVE_RST;
      active_reg  <= CSS_ACTIVE_RST;
    end else begin
      if (pend_we) begin
        pending_reg <= b3;
      end
      if (clr_act_reg) begin
        active_reg <= CSS_NO_SET;
      end else if (restart_edge && pending_reg < 8'(NUM_SETS)) begin
        active_reg <= pending_reg;
      end
    end
  end

  // Parameter storage, one entry per parameter.
  genvar g;
  generate
    for (g = 0; g < CSS_NUM_PAR; g++) begin : g_par
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          par_reg[g] <= CSS_PAR_DEF[g];
        end else if (par_we && pidx == CSS_PI_W'(g)) begin
          par_reg[g] <= new_val;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // AXI4-Lite slave.
  // ****************************************************************
  logic        aw_have;  // Write address held.
  logic        w_have;   // Write data held.
  logic [7:0]  aw_addr;  // Held write address.
  logic [31:0] w_data;   // Held write data.
  logic        w_lane0;  // Byte lane 0 enabled.
  logic        wr_fire;  // Both halves present; perform the write.

  assign wr_fire = aw_have && w_have && !bvalid;

  // Address and data are taken independently, in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      aw_have <= 1'b0;
      w_have  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_lane0 <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= CSS_RESP_OK;
    end else begin
      if (!aw_have && !bvalid) begin
        awready <= !(awvalid && awready);
      end
      if (!w_have && !bvalid) begin
        wready <= !(wvalid && wready);
      end
      if (awvalid && awready) begin
        aw_have <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_have  <= 1'b1;
        w_data  <= wdata;
        w_lane0 <= wstrb[0];
      end
      if (wr_fire) begin
        aw_have <= 1'b0;
        w_have  <= 1'b0;
        bvalid  <= 1'b1;
        // Unmapped addresses answer with a slave error.
        case (aw_addr)
          CSS_A_CTRL, CSS_A_STAT, CSS_A_MASK, CSS_A_INFO: bresp <= CSS_RESP_OK;
          default:                                        bresp <= CSS_RESP_ERR;
        endcase
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // Control, mask and status registers; set wins over a clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_reg  <= CSS_CTRL_RST;
      clr_act_reg <= 1'b0;
      mask_reg    <= '0;
      status_reg  <= '0;
    end else begin
      clr_act_reg <= 1'b0;
      if (wr_fire && w_lane0 && aw_addr == CSS_A_CTRL) begin
        enable_reg  <= w_data[0];
        clr_act_reg <= w_data[1];
      end
      if (wr_fire && w_lane0 && aw_addr == CSS_A_MASK) begin
        mask_reg <= w_data[CSS_NUM_EV-1:0];
      end
      if (wr_fire && w_lane0 && aw_addr == CSS_A_STAT) begin
        status_reg <= (status_reg & ~w_data[CSS_NUM_EV-1:0]) | ev;
      end else begin
        status_reg <= status_reg | ev;
      end
    end
  end

  // Read channel: one read at a time, answer one cycle after the address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= CSS_RESP_OK;
    end else begin
      if (!rvalid) begin
        arready <= !(arvalid && arready);
      end
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp  <= CSS_RESP_OK;
        case (araddr)
          CSS_A_CTRL: rdata <= {31'h0, enable_reg};
          CSS_A_STAT: rdata <= {27'h0, status_reg};
          CSS_A_MASK: rdata <= {27'h0, mask_reg};
          CSS_A_INFO: rdata <= {14'h0, machine_ok, active_valid, pending_reg, active_reg};
          default: begin
            rdata <= '0;
            rresp <= CSS_RESP_ERR;
          end
        endcase
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // Level interrupt; lags the status bit by one cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & mask_reg);
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic sel_take;
  assign sel_take = take && id_ok && enable_reg && b1 == CSS_CODE_SEL;

  reply_id_a: assert property (tx_valid |-> tx_id == {CSS_RPL_ID_HI, CSS_OWN_ADDR})
    else $error("reply identifier wrong");
  foreign_id_a: assert property (take && !id_ok |=> !tx_valid)
    else $error("reply to a foreign frame");
  sel_reply_a: assert property (sel_take && b2 <= CSS_OP_WRITE
      |=> tx_valid && tx_data[7:0] == CSS_CODE_SEL)
    else $error("selection request without reply");
  sel_read_a: assert property (sel_take && b2 == CSS_OP_READ
      |=> tx_data[15:8] == CSS_OP_READ && tx_data[23:16] == tx_data[31:24])
    else $error("read reply does not show active set");
  // A restart or a drop in the same cycle may move the active set legally.
  bad_index_a: assert property (sel_take && b2 == CSS_OP_WRITE && b3 >= 8'(NUM_SETS)
      && !restart_edge && !clr_act_reg
      |=> tx_data[15:8] == CSS_OP_BAD && $stable(pending_reg) && $stable(active_reg))
    else $error("bad set index not refused");
  no_switch_a: assert property (pend_we && !restart_edge && !clr_act_reg
      |=> pending_reg == $past(b3) && $stable(active_reg))
    else $error("set switched while running");
  // A refused read carries no value: the value bytes stay filled.
  no_set_a: assert property (take && id_ok && enable_reg && b1 == CSS_CODE_PRD
      && !active_valid |=> tx_data[39:32] == CSS_ST_NOSET && tx_data[31:16] == 16'hFFFF)
    else $error("parameter read without active set");
  // The table only changes through the write enable, so watching it suffices.
  machine_a: assert property (take && id_ok && enable_reg && b1 == CSS_CODE_PWR
      && active_valid && !machine_ok |=> tx_data[39:32] == CSS_ST_MACH && !$past(par_we))
    else $error("write accepted while machine busy");
  range_a: assert property (par_we |-> pidx_ok && new_val <= CSS_PAR_MAX[pidx]
      && new_val >= CSS_PAR_MIN[pidx] && machine_ok)
    else $error("parameter stored out of range");

  sel_ok_c: cover property (sel_take && pend_we ##[1:20] restart_edge);
  par_wr_c: cover property (par_we ##1 tx_valid ##[1:10] !tx_valid);
  irq_c:    cover property (irq);
endmodule : css_config_select
`default_nettype wire

// ===== rtl/css_sync.sv
`default_nettype none
// ****************************************************************
// Two-stage synchroniser for asynchronous pin levels.
// ****************************************************************
module css_sync
  import css_pkg::*;
#(
  parameter int W = CSS_NUM_PINS
) (
  // Clock and reset.
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Pin levels in and synchronised levels out.
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  // First stage is read by the second stage only.
  logic [W-1:0] meta_reg;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      // Each bit passes two flip-flops before any logic sees it.
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta_reg[g] <= 1'b0;
          q_out[g]    <= 1'b0;
        end else begin
          meta_reg[g] <= d_in[g];
          q_out[g]    <= meta_reg[g];
        end
      end
    end
  endgenerate
endmodule : css_sync
`default_nettype wire

// ===== shared/css_pkg.sv
`default_nettype none
// ****************************************************************
// Constants of the configuration set selection handler.
// ****************************************************************
package css_pkg;
  // Upper 21 bits of the 29-bit request identifier; low byte is the sender.
  localparam logic [20:0] CSS_REQ_ID_HI  = 21'h0CFF23;
  // Upper 21 bits of the reply identifier; low byte is our own address.
  localparam logic [20:0] CSS_RPL_ID_HI  = 21'h0CFF33;
  localparam logic [7:0]  CSS_OWN_ADDR   = 8'h03;
  localparam logic [3:0]  CSS_DLC        = 4'h8;
  // Request codes in data byte 1.
  localparam logic [7:0]  CSS_CODE_SEL   = 8'h80;
  localparam logic [7:0]  CSS_CODE_PRD   = 8'h81;
  localparam logic [7:0]  CSS_CODE_PWR   = 8'h86;
  // Selection operations in data byte 2.
  localparam logic [7:0]  CSS_OP_READ    = 8'h00;
  localparam logic [7:0]  CSS_OP_WRITE   = 8'h01;
  localparam logic [7:0]  CSS_OP_BAD     = 8'hFF;
  localparam logic [7:0]  CSS_FILL       = 8'hFF;
  localparam logic [7:0]  CSS_NO_SET     = 8'hFF;
  localparam int          CSS_NUM_SETS   = 20;
  // Set index after reset: the first set is the delivered default.
  localparam logic [7:0]  CSS_ACTIVE_RST = 8'h00;
  // Parameter reply status codes in data byte 5.
  localparam logic [7:0]  CSS_ST_OK      = 8'h00;
  localparam logic [7:0]  CSS_ST_NOSET   = 8'h01;
  localparam logic [7:0]  CSS_ST_MACH    = 8'h02;
  localparam logic [7:0]  CSS_ST_INDEX   = 8'h03;
  localparam logic [7:0]  CSS_ST_RANGE   = 8'h04;
  // Field selector in byte 3 of a parameter read.
  localparam logic [7:0]  CSS_FLD_MIN    = 8'h01;
  localparam logic [7:0]  CSS_FLD_MAX    = 8'h02;
  // Parameter table of the active set.
  localparam int          CSS_NUM_PAR    = 8;
  localparam int          CSS_PI_W       = 3;
  localparam logic [15:0] CSS_PAR_MIN [CSS_NUM_PAR] = '{default: 16'h0000};
  localparam logic [15:0] CSS_PAR_MAX [CSS_NUM_PAR] = '{default: 16'h00FF};
  localparam logic [15:0] CSS_PAR_DEF [CSS_NUM_PAR] = '{default: 16'h0010};
  // Register byte offsets on the AXI4-Lite port.
  localparam logic [7:0]  CSS_A_CTRL     = 8'h00;
  localparam logic [7:0]  CSS_A_STAT     = 8'h04;
  localparam logic [7:0]  CSS_A_MASK     = 8'h08;
  localparam logic [7:0]  CSS_A_INFO     = 8'h0C;
  localparam logic        CSS_CTRL_RST   = 1'b1;
  localparam logic [1:0]  CSS_RESP_OK    = 2'b00;
  localparam logic [1:0]  CSS_RESP_ERR   = 2'b10;
  // Event bit positions in the status and mask registers.
  localparam int          CSS_EV_SELRD   = 0;
  localparam int          CSS_EV_SELOK   = 1;
  localparam int          CSS_EV_SELBAD  = 2;
  localparam int          CSS_EV_PAROK   = 3;
  localparam int          CSS_EV_PARBAD  = 4;
  localparam int          CSS_NUM_EV     = 5;
  localparam int          CSS_NUM_PINS   = 5;
  // Frame handler states.
  typedef enum logic {CSS_IDLE, CSS_REPLY} css_state_t;
endpackage : css_pkg
`default_nettype wire

// ===== testbench/config_set_select_can_test.sv
`default_nettype none
// ****************************************************************
// Bench for the set selection handler.
// ****************************************************************
module config_set_select_can_test
  import css_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, rx_valid, rx_ready, rx_ide, tx_valid, tx_ready, tx_ide, irq;
  logic standstill_pin, lever_neutral_pin, park_brake_fitted_pin, park_brake_on_pin;
  logic restart_pin;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, rx_dlc, tx_dlc;
  logic [1:0]  bresp, rresp;
  logic [28:0] rx_id, tx_id;
  logic [63:0] rx_data, tx_data;
  int mismatches, checks;
  css_config_select uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .rx_valid, .rx_ready, .rx_id, .rx_ide, .rx_dlc, .rx_data, .tx_valid,
    .tx_ready, .tx_id, .tx_ide, .tx_dlc, .tx_data, .standstill_pin, .lever_neutral_pin,
    .park_brake_fitted_pin, .park_brake_on_pin, .restart_pin, .irq);
  css_requester mdl (.aclk, .rx_valid, .rx_ready, .rx_id, .rx_ide, .rx_dlc, .rx_data,
    .tx_valid, .tx_ready, .tx_data);
  initial begin
    aclk = 1'h0;
    forever #50 aclk = ~aclk;
  end
  // Watchdog: the tests need well under a thousand cycles.
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    finish_test;
  end
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    chk(64'(bresp), 64'(e));
    @(posedge aclk);
  endtask : wr
  // Expected value carries the response code above the read data.
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    chk(64'({rresp, rdata}), 64'(e));
    @(posedge aclk);
  endtask : rd
  // Expected reply holds bytes one to five; six to eight must be FFh.
  task automatic ask(input logic [31:0] q, input logic [39:0] e);
    mdl.req(q);
    chk(mdl.rep, {24'hFFFFFF, e});
  endtask : ask
  // Restart pulse long enough to pass the pin synchroniser.
  task automatic boot;
    restart_pin <= 1'h1;
    repeat (4) @(posedge aclk);
    restart_pin <= 1'h0;
    repeat (4) @(posedge aclk);
  endtask : boot
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, restart_pin} = 7'h0;
    {standstill_pin, lever_neutral_pin, park_brake_fitted_pin, park_brake_on_pin} = 4'h0;
    {awaddr, araddr, wdata, wstrb} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    wr(CSS_A_MASK, 32'h1F, CSS_RESP_OK);
    wr(8'h10, 32'h0, CSS_RESP_ERR);
    rd(8'h10, {CSS_RESP_ERR, 32'h0});
    ask(32'hFFFF0080, 40'hFF00000080);
    chk(64'({tx_ide, tx_dlc, tx_id}), 64'({1'h1, CSS_DLC, CSS_RPL_ID_HI, CSS_OWN_ADDR}));
    @(posedge aclk);
    chk(64'(irq), 64'h1);
    $display("test read done");
    mdl.quiet({CSS_REQ_ID_HI ^ 21'h1, 8'h27}, 32'hFFFF0080);
    chk(64'(tx_valid), 64'h0);
    mdl.quiet({CSS_REQ_ID_HI, 8'h27}, 32'hFFFF0280);
    chk(64'(tx_valid), 64'h0);
    wr(CSS_A_CTRL, 32'h0, CSS_RESP_OK);
    mdl.quiet({CSS_REQ_ID_HI, 8'h27}, 32'hFFFF0080);
    chk(64'(tx_valid), 64'h0);
    wr(CSS_A_CTRL, 32'h1, CSS_RESP_OK);
    $display("test refuse done");
    ask(32'hFF130180, 40'hFF00130180);
    ask(32'hFFFF0080, 40'hFF00000080);
    ask(32'hFF140180, 40'hFF0000FF80);
    rd(CSS_A_INFO, {CSS_RESP_OK, 32'h00011300});
    rd(CSS_A_STAT, {CSS_RESP_OK, 32'h7});
    wr(CSS_A_STAT, 32'h7, CSS_RESP_OK);
    repeat (2) @(posedge aclk);
    chk(64'(irq), 64'h0);
    $display("test select done");
    boot;
    ask(32'hFFFF0080, 40'hFF13130080);
    wr(CSS_A_CTRL, 32'h3, CSS_RESP_OK);
    ask(32'hFFFF0080, 40'hFFFFFF0080);
    ask(32'hFFFF0081, 40'h01FFFF0081);
    $display("test activation done");
    boot;
    ask(32'h20000086, 40'h0220000086);
    {standstill_pin, lever_neutral_pin, park_brake_fitted_pin} <= 3'h7;
    repeat (4) @(posedge aclk);
    ask(32'h20000086, 40'h0220000086);
    park_brake_on_pin <= 1'h1;
    repeat (4) @(posedge aclk);
    ask(32'h20000086, 40'h0020000086);
    ask(32'hFFFF0081, 40'h0020000081);
    ask(32'hFF020081, 40'h00FF000081);
    ask(32'h20000886, 40'h0320000886);
    ask(32'h00010086, 40'h0400010086);
    $display("test parameters done");
    finish_test;
  end
endmodule : config_set_select_can_test
`default_nettype wire

// ===== testbench/css_requester.sv
`default_nettype none
// ****************************************************************
// Vehicle controller side: sends one request, takes its reply.
// ****************************************************************
module css_requester
  import css_pkg::*;
(
  // Clock.
  input  wire logic        aclk,
  // Request frame.
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic [28:0]      rx_id,
  output logic             rx_ide,
  output logic [3:0]       rx_dlc,
  output logic [63:0]      rx_data,
  // Reply frame.
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [63:0] tx_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [63:0] rep; // Last reply taken.
  initial begin
    {rx_valid, tx_ready} = 2'h0;
    {rx_id, rx_ide, rx_dlc, rx_data} = '0;
  end
  // Sender address 27h is arbitrary; unused bytes are filled with FFh.
  task automatic req(input logic [31:0] q);
    rx_id <= {CSS_REQ_ID_HI, 8'h27};
    rx_ide <= 1'h1;
    rx_dlc <= CSS_DLC;
    rx_data <= {32'hFFFFFFFF, q};
    rx_valid <= 1'h1;
    do @(posedge aclk); while (!rx_ready);
    rx_valid <= 1'h0;
    // Released lines show the inverse so a stale read cannot pass.
    rx_data <= ~{32'hFFFFFFFF, q};
    tx_ready <= 1'h1;
    do @(posedge aclk); while (!tx_valid);
    rep = tx_data;
    tx_ready <= 1'h0;
    @(posedge aclk);
  endtask : req
  // A frame that owes no reply: offered, taken, released, with no reply awaited.
  task automatic quiet(input logic [28:0] id, input logic [31:0] q);
    rx_id <= id;
    rx_ide <= 1'h1;
    rx_dlc <= CSS_DLC;
    rx_data <= {32'hFFFFFFFF, q};
    rx_valid <= 1'h1;
    do @(posedge aclk); while (!rx_ready);
    rx_valid <= 1'h0;
    rx_data <= ~{32'hFFFFFFFF, q};
    @(posedge aclk);
  endtask : quiet
endmodule : css_requester
`default_nettype wire
